// file: rtu_pkg.sv
// Package for the return instruction unit: opcodes, widths, field positions.
// Assumes a 14-bit instruction word and a 13-bit program counter.
package rtu_pkg;
    localparam int INSN_W  = 14;
    localparam int PC_W    = 13;
    localparam int DATA_W  = 8;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W    = 3;

    localparam logic [INSN_W-1:0] OP_RETURN = 14'h0008;
    localparam logic [INSN_W-1:0] OP_RETFI  = 14'h0009;
    localparam logic [5:0]        OP_RETLIT_HI = 6'h0D;
    localparam int LIT_LSB   = 0;
    localparam int OPHI_LSB  = 8;
    localparam int IRQ_EN_BIT = 7;

    localparam logic [SP_W-1:0]   SP_ONE = 3'h1;
    localparam logic [DATA_W-1:0] W_RESET = 8'h00;
    localparam logic [DATA_W-1:0] INTCTL_RESET = 8'h00;
    localparam logic [PC_W-1:0]   PC_RESET = 13'h0000;

    typedef enum logic [1:0] {
        RTU_RET_NONE,
        RTU_RET_SUB,
        RTU_RET_INT,
        RTU_RET_LIT
    } rtu_kind_e;

    typedef enum logic {
        RTU_EXEC,
        RTU_FLUSH
    } rtu_state_e;
endpackage

// file: rtu_return_unit.sv
// Return instruction execution: pops the return stack into the PC.
// Assumes one instruction word offered per cycle by the decode stage.
//
// Summary of operation
// - Return from interrupt pops the stack and loads top of stack into PC.
// - Return from interrupt sets the global enable, bit seven of control.
// - Return from interrupt is one word and takes two instruction cycles.
// - Return with literal loads the working register with its 8-bit field.
// - Return with literal loads the PC with the popped return address.
// - Return with literal is one word and takes two instruction cycles.
// - Plain return pops the stack into the PC and changes nothing else.
// - Plain return takes two instruction cycles.
`timescale 1ns/10ps
`default_nettype none
module rtu_return_unit
    import rtu_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic [INSN_W-1:0] insn,
    input  wire logic              insn_valid,
    input  wire logic              call_push,
    input  wire logic [PC_W-1:0]   call_addr,
    input  wire logic              intctl_write,
    input  wire logic [DATA_W-1:0] intctl_wdata,
    input  wire logic              irq_taken,
    output logic                   pop_pulse,
    output var  logic              pc_load,
    output var  logic [PC_W-1:0]   pc_value,
    output var  logic [DATA_W-1:0] working_reg,
    output var  logic [DATA_W-1:0] interrupt_control_reg,
    output logic                   fetch_idle,
    output logic                   busy
);
    rtu_state_e      state;
    rtu_kind_e       kind;
    logic [PC_W-1:0] top_of_stack;

    function automatic rtu_kind_e decode(input logic [INSN_W-1:0] w);
        if (w == OP_RETURN) begin
            decode = RTU_RET_SUB;
        end else if (w == OP_RETFI) begin
            decode = RTU_RET_INT;
        end else if (w[INSN_W-1:OPHI_LSB] == OP_RETLIT_HI) begin
            decode = RTU_RET_LIT;
        end else begin
            decode = RTU_RET_NONE;
        end
    endfunction

    always_comb begin
        kind = RTU_RET_NONE;
        if (insn_valid && state == RTU_EXEC) begin
            kind = decode(insn);
        end
    end

    // Pop in the first cycle; calls are ignored then to avoid a collision
    assign pop_pulse  = (kind != RTU_RET_NONE);
    assign fetch_idle = (state == RTU_FLUSH);
    assign busy       = fetch_idle;

    rtu_stack u_stack (
        .core_clk     (core_clk),
        .rst          (rst),
        .push         (call_push && !pop_pulse),
        .push_addr    (call_addr),
        .pop          (pop_pulse),
        .top_of_stack (top_of_stack)
    );

    // Two cycles per return: execute, then one flushed fetch
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= RTU_EXEC;
        end else if (state == RTU_FLUSH) begin
            state <= RTU_EXEC;
        end else if (pop_pulse) begin
            state <= RTU_FLUSH;
        end
    end

    // PC loads from the registered top at the edge where the pop lands
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pc_load  <= 1'h0;
            pc_value <= PC_RESET;
        end else begin
            pc_load  <= pop_pulse;
            if (pop_pulse) begin
                pc_value <= top_of_stack;
            end
        end
    end

    // Working register changes only for return with literal
    always_ff @(posedge core_clk) begin
        if (rst) begin
            working_reg <= W_RESET;
        end else if (kind == RTU_RET_LIT) begin
            working_reg <= insn[LIT_LSB +: DATA_W];
        end
    end

    // Interrupt acceptance clears the enable; the return sets it and wins
    always_ff @(posedge core_clk) begin
        if (rst) begin
            interrupt_control_reg <= INTCTL_RESET;
        end else begin
            if (intctl_write) begin
                interrupt_control_reg <= intctl_wdata;
            end
            if (irq_taken) begin
                interrupt_control_reg[IRQ_EN_BIT] <= 1'h0;
            end
            if (kind == RTU_RET_INT) begin
                interrupt_control_reg[IRQ_EN_BIT] <= 1'h1;
            end
        end
    end
    // No status flag output exists here, so none can change.
endmodule
`default_nettype wire

// file: rtu_return_unit_props.sv
// Checker on the return unit ports.
// Assumes one clock and a synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module rtu_return_unit_props
    import rtu_pkg::*;
(
    input wire logic [0:0]        core_clk,
    input wire logic [0:0]        rst,
    input wire logic [INSN_W-1:0] insn,
    input wire logic [0:0]        pop_pulse,
    input wire logic [0:0]        pc_load,
    input wire logic [PC_W-1:0]   pc_value,
    input wire logic [DATA_W-1:0] working_reg,
    input wire logic [DATA_W-1:0] interrupt_control_reg,
    input wire logic [0:0]        busy
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire logic rfi = pop_pulse && insn == OP_RETFI;
    wire logic rlw = pop_pulse && insn[INSN_W-1:OPHI_LSB] == OP_RETLIT_HI;
    pop_load_a: assert property (pop_pulse |=> pc_load)
        else $error("no pc load");
    load_why_a: assert property (pc_load |-> $past(pop_pulse))
        else $error("stray pc load");
    enable_set_a: assert property (rfi |=> interrupt_control_reg[IRQ_EN_BIT])
        else $error("enable not set");
    lit_w_a: assert property (rlw |=> working_reg == $past(insn[7:0]))
        else $error("literal lost");
    keep_w_a: assert property (pop_pulse&&!rlw |=> $stable(working_reg))
        else $error("w changed");
    two_cyc_a: assert property (pop_pulse |=> busy ##1 !busy)
        else $error("not two cycles");
    no_retake_a: assert property (busy |-> !pop_pulse)
        else $error("taken while busy");
    pc_hold_a: assert property (!pc_load |-> $stable(pc_value))
        else $error("pc moved");
    cover property (rfi);
    cover property (rlw);
    cover property (pop_pulse && insn == OP_RETURN);
endmodule
bind rtu_return_unit rtu_return_unit_props u_props (.core_clk, .rst, .insn,
    .pop_pulse, .pc_load, .pc_value, .working_reg, .interrupt_control_reg,
    .busy);
`default_nettype wire

// file: rtu_return_unit_tb_top.sv
// Bench: random calls and returns, stack kept in a queue.
// Assumes the answer lands at the taken edge, half a cycle before the check.
`timescale 1ns/10ps
`default_nettype none
module rtu_return_unit_tb_top;
    import rtu_pkg::*;
    logic              core_clk = 0, rst = 1, insn_valid = 0;
    logic              call_push = 0, intctl_write = 0, irq_taken = 0;
    logic              pop_pulse, pc_load, fetch_idle, busy;
    logic [INSN_W-1:0] insn = '0;
    logic [PC_W-1:0]   call_addr = '0, pc_value, stk[$];
    logic [7:0]        intctl_wdata = '0, s = 8'h4E, w = '0;
    logic [7:0]        working_reg, interrupt_control_reg;
    logic [1:0]        kd;
    int                err_total = 0, n_compared = 0;
    always #20 core_clk = ~core_clk;
    rtu_return_unit dut (.core_clk, .rst, .insn, .insn_valid, .call_push,
        .call_addr, .intctl_write, .intctl_wdata, .irq_taken,
        .pop_pulse, .pc_load, .pc_value, .working_reg,
        .interrupt_control_reg, .fetch_idle, .busy);
    function automatic logic [7:0] nx(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    // Return's set of the enable wins over a same-cycle write or clear
    function automatic logic [7:0] ctl_of(input logic [1:0] t, input logic q,
                                          input logic [7:0] d);
        if (t == 2'h2) begin
            return d | 8'h80;
        end
        return q ? d & 8'h7F : d;
    endfunction
    task automatic chk(input string n, input logic [PC_W-1:0] e, g);
        n_compared++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            err_total++;
        end
    endtask
    task automatic summarize;
        if (err_total == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        summarize();
    end
    initial begin
        repeat (4) @(negedge core_clk);
        rst = 0;
        // Reset values, then a word that is not a return must be ignored
        chk("pc_value", PC_RESET, pc_value);
        chk("working_reg", W_RESET, working_reg);
        chk("ic", INTCTL_RESET, interrupt_control_reg);
        chk("fetch_idle", 0, fetch_idle);
        insn = {OP_RETLIT_HI ^ 6'h01, 8'h00};
        insn_valid = 1;
        #1 chk("pop_pulse", 0, pop_pulse);
        @(negedge core_clk);
        insn_valid = 0;
        chk("pc_load", 0, pc_load);
        repeat (40) begin
            repeat (s[1:0] + 1) begin
                @(negedge core_clk);
                call_push = 1;
                call_addr = {s[4:0], nx(s)};
                stk.push_back(call_addr);
                s = nx(s);
            end
            // The first return follows the last push directly
            while (stk.size() > 0) begin
                @(negedge core_clk);
                s = nx(s);
                kd = s[1:0] == 2'h0 ? 2'h1 : s[1:0];
                w = kd == 2'h3 ? nx(s) : w;
                case (kd)
                    2'h1: insn = OP_RETURN;
                    2'h2: insn = OP_RETFI;
                    default: insn = {OP_RETLIT_HI, w};
                endcase
                insn_valid = 1;
                intctl_write = 1;
                intctl_wdata = s ^ 8'h5A;
                irq_taken = s[3];
                // A push in the pop cycle must be dropped
                call_push = s[5];
                call_addr = {s[4:0], s};
                #1 chk("pop_pulse", 1, pop_pulse);
                @(negedge core_clk);
                // Holding valid offers the same return while busy
                insn_valid = s[2];
                intctl_write = 0;
                call_push = 0;
                chk("pop_pulse", 0, pop_pulse);
                chk("fetch_idle", 1, fetch_idle);
                chk("busy", 1, busy);
                chk("pc_load", 1, pc_load);
                chk("pc_value", stk.pop_back(), pc_value);
                chk("working_reg", w, working_reg);
                chk("ic", ctl_of(kd, irq_taken, intctl_wdata),
                    interrupt_control_reg);
                irq_taken = 0;
                @(negedge core_clk);
                insn_valid = 0;
                chk("pc_load", 0, pc_load);
                chk("fetch_idle", 0, fetch_idle);
                chk("busy", 0, busy);
            end
        end
        summarize();
    end
endmodule
`default_nettype wire

// file: rtu_stack.sv
// Return stack memory: circular, eight entries, registered top read.
// Assumes push and pop are never asserted together.
`timescale 1ns/10ps
`default_nettype none
module rtu_stack
    import rtu_pkg::*;
(
    input  wire logic            core_clk,
    input  wire logic            rst,
    input  wire logic            push,
    input  wire logic [PC_W-1:0] push_addr,
    input  wire logic            pop,
    output var  logic [PC_W-1:0] top_of_stack
);
    logic [PC_W-1:0] mem [STACK_DEPTH];
    logic [SP_W-1:0] sp;
    logic [SP_W-1:0] next_sp;

    // Overflow silently wraps, as a circular hardware stack does
    always_comb begin
        next_sp = sp;
        if (push) begin
            next_sp = sp + SP_ONE;
        end else if (pop) begin
            next_sp = sp - SP_ONE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sp <= '0;
        end else begin
            sp <= next_sp;
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[sp] <= push_addr;
        end
    end

    // Top is read from the updated pointer so it is ready next cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            top_of_stack <= PC_RESET;
        end else if (push) begin
            top_of_stack <= push_addr;
        end else begin
            top_of_stack <= mem[next_sp - SP_ONE];
        end
    end
endmodule
`default_nettype wire
